// ---- rtl/psmta_pkg.sv ----
// constants for the special-modes and test-access register bank
`default_nettype none
package psmta_pkg;
  // register indices on the management register port
  localparam logic [4:0] ADDR_SPECIAL_MODES = 5'h12;
  localparam logic [4:0] ADDR_TEST_CTL = 5'h14;
  localparam logic [4:0] ADDR_TEST_RD_LOW = 5'h15;
  localparam logic [4:0] ADDR_TEST_RD_HIGH = 5'h16;
  localparam logic [4:0] ADDR_TEST_WR_DATA = 5'h17;

  // special-modes field positions
  localparam int SM_IFMODE_MSB = 15;
  localparam int SM_IFMODE_LSB = 14;
  localparam int SM_CLKFREQ = 13;
  localparam int SM_DSP_BP = 12;
  localparam int SM_SQ_BP = 11;
  localparam int SM_RSVD10 = 10;
  localparam int SM_PLL_BP = 9;
  localparam int SM_ADC_BP = 8;
  localparam int SM_MODE_MSB = 7;
  localparam int SM_MODE_LSB = 5;
  localparam int SM_ADDR_MSB = 4;
  localparam int SM_ADDR_LSB = 0;

  // test control field positions
  localparam int TC_RD_STROBE = 15;
  localparam int TC_WR_STROBE = 14;
  localparam int TC_TEST_MODE = 10;
  localparam int TC_RD_ADDR_MSB = 9;
  localparam int TC_RD_ADDR_LSB = 5;
  localparam int TC_WR_ADDR_MSB = 4;
  localparam int TC_WR_ADDR_LSB = 0;

  // values after reset
  localparam logic [1:0] RST_IFMODE = 2'h0;
  localparam logic RST_CLKFREQ = 1'h0;
  localparam logic RST_BYPASS = 1'h0;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [4:0] RST_ADDR = 5'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [31:0] RST_TEST_REG = 32'h0000_0000;

  // cycles after reset release before the synchronised straps are taken
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

  // data width of the read-data registers
  localparam int HALF_WIDTH = 16;

  // width of each internal test register, by address
  function automatic logic [5:0] test_reg_width(input logic [4:0] addr);
    if (addr < 5'h08) begin
      test_reg_width = 6'h08;
    end else if (addr < 5'h10) begin
      test_reg_width = 6'h10;
    end else begin
      test_reg_width = 6'h20;
    end
  endfunction

  function automatic logic [31:0] test_reg_mask(input logic [4:0] addr);
    logic [5:0] w;
    w = test_reg_width(addr);
    test_reg_mask = (w == 6'h20) ? 32'hffff_ffff : ((32'h0000_0001 << w) - 32'h0000_0001);
  endfunction
endpackage
`default_nettype wire

// ---- rtl/psmta_test_regs.sv ----
// internal testability and configuration registers behind the test access port
`timescale 1ns/1ps
`default_nettype none
module psmta_test_regs #(
  parameter int NUM_REGS = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write side
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  // read side
  input wire logic [4:0] rd_addr,
  output logic [31:0] rd_value,
  output logic rd_wide
);
  logic [31:0] regs [NUM_REGS];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= psmta_pkg::RST_TEST_REG;
      end
    end else if (wr_en) begin
      // only sixteen bits arrive per write; wide registers keep their upper half
      regs[wr_addr] <= (regs[wr_addr] & 32'hffff_0000)
                     | ({16'h0000, wr_data} & psmta_pkg::test_reg_mask(wr_addr));
    end
  end

  always_comb begin
    rd_value = regs[rd_addr] & psmta_pkg::test_reg_mask(rd_addr);
    rd_wide = psmta_pkg::test_reg_width(rd_addr) > 6'(psmta_pkg::HALF_WIDTH);
  end
endmodule
`default_nettype wire

// ---- rtl/psmta_bank.sv ----
// special-modes register and indirect test access port of the phy management bank
`timescale 1ns/1ps
`default_nettype none
// Operation
// - interface mode zero selects mii; other reserved
// - clock frequency bit read-only, zero means 25MHz
// - bypass bits read-write; dsp, squelch reset zero
// - three-bit phy mode field defaults to mode strap, read-write
// - station address defaults to strap, drives outputs
// - read strobe copies selected register, self-clears
// - write strobe loads selected register, self-clears
// - test mode enable bit, resets to zero
// - read address selects source, resets zero
// - write address selects target, resets zero
// - low read data gets low sixteen bits
// - high read data zero for narrow registers
// - high read data gets bits from sixteen up
// - write-data register holds strobe value, resets zero
module psmta_bank (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  // management register port
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // strap pins
  input wire logic [4:0] strap_address_pins,
  input wire logic [2:0] strap_mode_pins,
  // configuration outputs to the phy
  output logic [1:0] interface_mode_sel,
  output logic input_clock_freq_sel,
  output logic dsp_bypass,
  output logic squelch_bypass,
  output logic pll_bypass,
  output logic adc_bypass,
  output logic [2:0] phy_mode,
  output logic [4:0] station_address,
  output logic test_mode_en
);
  logic [4:0] addr_s1, addr_s2;
  logic [2:0] mode_s1, mode_s2;
  logic [1:0] strap_cnt;
  logic strap_done;
  logic strap_load;
  logic rsvd10;
  logic rd_strobe, wr_strobe;
  logic [4:0] rd_addr, wr_addr;
  logic [15:0] test_write_data;
  logic [15:0] test_read_data_low, test_read_data_high;
  logic [31:0] tr_value;
  logic tr_wide;
  logic wr_sm, wr_ctl, wr_wd;
  logic [15:0] next_rdata;

  assign wr_sm = mgmt_wr && mgmt_addr == psmta_pkg::ADDR_SPECIAL_MODES;
  assign wr_ctl = mgmt_wr && mgmt_addr == psmta_pkg::ADDR_TEST_CTL;
  assign wr_wd = mgmt_wr && mgmt_addr == psmta_pkg::ADDR_TEST_WR_DATA;
  assign strap_load = !strap_done && strap_cnt == psmta_pkg::STRAP_SETTLE_CYCLES;

  // strap pins are asynchronous to clk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_s1 <= psmta_pkg::RST_ADDR;
      addr_s2 <= psmta_pkg::RST_ADDR;
      mode_s1 <= psmta_pkg::RST_MODE;
      mode_s2 <= psmta_pkg::RST_MODE;
    end else begin
      addr_s1 <= strap_address_pins;
      addr_s2 <= addr_s1;
      mode_s1 <= strap_mode_pins;
      mode_s2 <= mode_s1;
    end
  end

  // straps are taken once, after the synchroniser has filled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      strap_done <= strap_load;
    end
  end

  // special-modes fields ignore soft_reset on purpose
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interface_mode_sel <= psmta_pkg::RST_IFMODE;
      input_clock_freq_sel <= psmta_pkg::RST_CLKFREQ;
      dsp_bypass <= psmta_pkg::RST_BYPASS;
      squelch_bypass <= psmta_pkg::RST_BYPASS;
      rsvd10 <= psmta_pkg::RST_BYPASS;
      pll_bypass <= psmta_pkg::RST_BYPASS;
      adc_bypass <= psmta_pkg::RST_BYPASS;
      phy_mode <= psmta_pkg::RST_MODE;
      station_address <= psmta_pkg::RST_ADDR;
    end else if (strap_load) begin
      phy_mode <= mode_s2;
      station_address <= addr_s2;
    end else if (wr_sm) begin
      // reserved interface mode values are stored as written; software must not use them
      interface_mode_sel <= mgmt_wdata[psmta_pkg::SM_IFMODE_MSB:psmta_pkg::SM_IFMODE_LSB];
      dsp_bypass <= mgmt_wdata[psmta_pkg::SM_DSP_BP];
      squelch_bypass <= mgmt_wdata[psmta_pkg::SM_SQ_BP];
      rsvd10 <= mgmt_wdata[psmta_pkg::SM_RSVD10];
      pll_bypass <= mgmt_wdata[psmta_pkg::SM_PLL_BP];
      adc_bypass <= mgmt_wdata[psmta_pkg::SM_ADC_BP];
      phy_mode <= mgmt_wdata[psmta_pkg::SM_MODE_MSB:psmta_pkg::SM_MODE_LSB];
      station_address <= mgmt_wdata[psmta_pkg::SM_ADDR_MSB:psmta_pkg::SM_ADDR_LSB];
    end
  end

  // test access control: strobes live one cycle, a new write overrides
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_strobe <= 1'b0;
      wr_strobe <= 1'b0;
      test_mode_en <= 1'b0;
      rd_addr <= psmta_pkg::RST_ADDR;
      wr_addr <= psmta_pkg::RST_ADDR;
    end else if (soft_reset) begin
      rd_strobe <= 1'b0;
      wr_strobe <= 1'b0;
      test_mode_en <= 1'b0;
      rd_addr <= psmta_pkg::RST_ADDR;
      wr_addr <= psmta_pkg::RST_ADDR;
    end else if (wr_ctl) begin
      rd_strobe <= mgmt_wdata[psmta_pkg::TC_RD_STROBE];
      wr_strobe <= mgmt_wdata[psmta_pkg::TC_WR_STROBE];
      test_mode_en <= mgmt_wdata[psmta_pkg::TC_TEST_MODE];
      rd_addr <= mgmt_wdata[psmta_pkg::TC_RD_ADDR_MSB:psmta_pkg::TC_RD_ADDR_LSB];
      wr_addr <= mgmt_wdata[psmta_pkg::TC_WR_ADDR_MSB:psmta_pkg::TC_WR_ADDR_LSB];
    end else begin
      rd_strobe <= 1'b0;
      wr_strobe <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_write_data <= psmta_pkg::RST_WORD;
    end else if (soft_reset) begin
      test_write_data <= psmta_pkg::RST_WORD;
    end else if (wr_wd) begin
      test_write_data <= mgmt_wdata;
    end
  end

  psmta_test_regs #(.NUM_REGS(32)) u_test_regs (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(wr_strobe),
    .wr_addr(wr_addr),
    .wr_data(test_write_data),
    .rd_addr(rd_addr),
    .rd_value(tr_value),
    .rd_wide(tr_wide)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_read_data_low <= psmta_pkg::RST_WORD;
      test_read_data_high <= psmta_pkg::RST_WORD;
    end else if (soft_reset) begin
      test_read_data_low <= psmta_pkg::RST_WORD;
      test_read_data_high <= psmta_pkg::RST_WORD;
    end else if (rd_strobe) begin
      test_read_data_low <= tr_value[15:0];
      test_read_data_high <= tr_wide ? tr_value[31:16] : psmta_pkg::RST_WORD;
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    unique case (mgmt_addr)
      psmta_pkg::ADDR_SPECIAL_MODES: begin
        next_rdata = {interface_mode_sel, input_clock_freq_sel, dsp_bypass, squelch_bypass,
                      rsvd10, pll_bypass, adc_bypass, phy_mode, station_address};
      end
      psmta_pkg::ADDR_TEST_CTL: begin
        next_rdata = {rd_strobe, wr_strobe, 3'h0, test_mode_en, rd_addr, wr_addr};
      end
      psmta_pkg::ADDR_TEST_RD_LOW: next_rdata = test_read_data_low;
      psmta_pkg::ADDR_TEST_RD_HIGH: next_rdata = test_read_data_high;
      psmta_pkg::ADDR_TEST_WR_DATA: next_rdata = test_write_data;
      default: next_rdata = 16'h0000;
    endcase
  end

  // read data stands until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_rdata <= psmta_pkg::RST_WORD;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      if (mgmt_rd) begin
        mgmt_rdata <= next_rdata;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  rd_strobe_clear_a: assert property (rd_strobe && !wr_ctl |=> !rd_strobe)
    else $error("read strobe did not self-clear");
  rd_strobe_set_a: assert property (wr_ctl && !soft_reset && mgmt_wdata[15] |=> rd_strobe)
    else $error("read strobe not raised by write");
  wr_strobe_clear_a: assert property (wr_strobe && !wr_ctl |=> !wr_strobe)
    else $error("write strobe did not self-clear");
  rd_low_copy_a: assert property (rd_strobe && !soft_reset
    |=> test_read_data_low == $past(tr_value[15:0]))
    else $error("low read data not copied");
  rd_high_narrow_a: assert property (rd_strobe && !soft_reset && !tr_wide
    |=> test_read_data_high == 16'h0000)
    else $error("high read data not cleared for narrow register");
  rd_high_wide_a: assert property (rd_strobe && !soft_reset && tr_wide
    |=> test_read_data_high == $past(tr_value[31:16]))
    else $error("high read data not upper half");
  clk_freq_zero_a: assert property (input_clock_freq_sel == 1'b0)
    else $error("clock frequency select not zero");
  soft_keep_addr_a: assert property (soft_reset && strap_done && !wr_sm
    |=> $stable(station_address) && $stable(phy_mode))
    else $error("soft reset disturbed special modes");
  soft_clear_ctl_a: assert property (soft_reset |=> !test_mode_en && rd_addr == 5'h00
    && wr_addr == 5'h00 && test_write_data == 16'h0000)
    else $error("soft reset did not clear test control");
  strap_take_a: assert property (strap_load |=> station_address == $past(addr_s2)
    && phy_mode == $past(mode_s2))
    else $error("straps not taken");

  read_cycle_c: cover property (wr_ctl && mgmt_wdata[15] ##1 rd_strobe ##1 mgmt_rd);
  write_cycle_c: cover property (wr_wd ##[1:4] wr_ctl && mgmt_wdata[14]);
  wide_read_c: cover property (rd_strobe && tr_wide);
  soft_reset_c: cover property (soft_reset && strap_done);
endmodule
`default_nettype wire

// ---- testbench/psmta_mgmt_ctrl.sv ----
// station management controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module psmta_mgmt_ctrl (
  // clock
  input wire logic clk,
  // register port
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [4:0] mgmt_addr,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  initial begin
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_addr = 5'h1f;
    mgmt_wdata = 16'hffff;
  end
  // released bus shows the inverse, so stale values never pass as fresh
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    mgmt_wr = 1'b1;
    mgmt_addr = a;
    mgmt_wdata = d;
    @(negedge clk);
    mgmt_wr = 1'b0;
    mgmt_addr = ~a;
    mgmt_wdata = ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    mgmt_rd = 1'b1;
    mgmt_addr = a;
    @(negedge clk);
    mgmt_rd = 1'b0;
    mgmt_addr = ~a;
    d = mgmt_rvalid ? mgmt_rdata : 16'hxxxx;
  endtask
  task automatic smw(input logic [15:0] d);
    wr(5'h12, d & 16'h3fff);
  endtask
  task automatic tw(input logic [4:0] ta, input logic [15:0] d, input logic tm);
    wr(5'h17, d);
    // write strobe is bit 14 of the control word
    wr(5'h14, {5'h08, tm, 5'h00, ta});
  endtask
  task automatic trd(input logic [4:0] ta, input logic tm, output logic [15:0] lo,
                     output logic [15:0] hi);
    // spare cycle lets a pending write strobe finish first
    @(negedge clk);
    // read strobe is bit 15 of the control word
    wr(5'h14, {5'h10, tm, ta, 5'h00});
    rd(5'h15, lo);
    rd(5'h16, hi);
  endtask
endmodule
`default_nettype wire

// ---- testbench/phy_special_modes_test_access_tb.sv ----
// self-checking bench for the special-modes and test access bank
`timescale 1ns/1ps
`default_nettype none
module phy_special_modes_test_access_tb;
  logic clk, rst_n, soft_reset, mgmt_wr, mgmt_rd, mgmt_rvalid, icf, dsp, sq, pll, adc, tme;
  logic [4:0] mgmt_addr, station_address, strap_a, ta;
  logic [15:0] mgmt_wdata, mgmt_rdata, got, hi, d, sm, ctl, wdat, mlo, mhi;
  logic [2:0] phy_mode, strap_m;
  logic [1:0] ifm;
  logic [4:0] al[6] = '{5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17};
  logic [4:0] tl[6] = '{5'h03, 5'h07, 5'h08, 5'h0f, 5'h10, 5'h1f};
  int n_errors, checks, tr[32];
  psmta_bank u_psmta_bank (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .strap_address_pins(strap_a),
    .strap_mode_pins(strap_m), .interface_mode_sel(ifm), .input_clock_freq_sel(icf),
    .dsp_bypass(dsp), .squelch_bypass(sq), .pll_bypass(pll), .adc_bypass(adc),
    .phy_mode(phy_mode), .station_address(station_address), .test_mode_en(tme));
  psmta_mgmt_ctrl u_psmta_mgmt_ctrl (.clk(clk), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid));
  always #20 clk = ~clk;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (e !== g) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] exp_rd(input logic [4:0] a);
    case (a)
      5'h12: return sm;
      5'h14: return ctl;
      5'h15: return mlo;
      5'h16: return mhi;
      5'h17: return wdat;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic read_all(input string t);
    foreach (al[i]) begin
      u_psmta_mgmt_ctrl.rd(al[i], got);
      chk("register", exp_rd(al[i]), got);
    end
    chk("pins", {sm[15:11], sm[9:0], ctl[10]}, {ifm, icf, dsp, sq, pll, adc, phy_mode,
        station_address, tme});
    $display("test %s done", t);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    n_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h0bcec4fd));
    clk = 1'b0;
    rst_n = 1'b0;
    soft_reset = 1'b0;
    strap_a = 5'($urandom);
    strap_m = 3'($urandom);
    n_errors = 0;
    checks = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    sm = {8'h00, strap_m, strap_a};
    ctl = 16'h0000;
    wdat = 16'h0000;
    mlo = 16'h0000;
    mhi = 16'h0000;
    foreach (tr[i]) tr[i] = 0;
    read_all("reset");
    repeat (4) begin
      d = 16'($urandom);
      u_psmta_mgmt_ctrl.smw(d);
      u_psmta_mgmt_ctrl.wr(5'h13, ~d);
      sm = d & 16'h1fff;
      read_all("special modes");
    end
    foreach (tl[i]) begin
      ta = tl[i];
      d = 16'($urandom);
      u_psmta_mgmt_ctrl.tw(ta, d, i[0]);
      wdat = d;
      // narrow registers keep only their width; wide ones keep the upper half
      if (ta < 5'h08) tr[ta] = int'(d & 16'h00ff);
      else if (ta < 5'h10) tr[ta] = int'(d);
      else tr[ta] = (tr[ta] & 32'hffff_0000) | int'(d);
      u_psmta_mgmt_ctrl.trd(ta, i[0], got, hi);
      ctl = {5'h00, i[0], ta, 5'h00};
      mlo = 16'(tr[ta]);
      mhi = 16'(tr[ta] >>> 16);
      chk("read low", mlo, got);
      chk("read high", mhi, hi);
      read_all("test access");
    end
    @(negedge clk);
    soft_reset = 1'b1;
    @(negedge clk);
    soft_reset = 1'b0;
    ctl = 16'h0000;
    wdat = 16'h0000;
    mlo = 16'h0000;
    mhi = 16'h0000;
    read_all("soft reset");
    finish_test();
  end
endmodule
`default_nettype wire
